// ### logic/qhs_params.svh
`ifndef QHS_PARAMS_SVH
`define QHS_PARAMS_SVH

`define QHS_CLK_PERIOD_NS 10
`define QHS_TICK_US       100
`define QHS_TON_DEL_US    25600
`define QHS_TOFF_DEL_US   3200
`define QHS_OPEN_DEL_US   900000
`define QHS_OC_TIME_US    6400
`define QHS_TICK_CYCLES   (`QHS_TICK_US * 1000 / `QHS_CLK_PERIOD_NS)
`define QHS_TON_TICKS     (`QHS_TON_DEL_US / `QHS_TICK_US)
`define QHS_TOFF_TICKS    (`QHS_TOFF_DEL_US / `QHS_TICK_US)
`define QHS_OPEN_TICKS    (`QHS_OPEN_DEL_US / `QHS_TICK_US)
`define QHS_OC_TICKS      (`QHS_OC_TIME_US / `QHS_TICK_US)

`define QHS_DUTY_LOW_PCT  1
`define QHS_DUTY_HIGH_PCT 2
`define QHS_DUTY_OPEN_PCT 4
`define QHS_DC_LOW        2'h0
`define QHS_DC_HIGH       2'h1
`define QHS_DC_OPEN       2'h2

`define QHS_OFF_CTRL      5'h00
`define QHS_OFF_PORT_REQ  5'h04
`define QHS_OFF_OC_TIME   5'h08
`define QHS_OFF_STATUS    5'h0C

`define QHS_CTRL_SEL      0
`define QHS_CTRL_OPENCIRCUIT_ENABLE     1
`define QHS_CTRL_RETRY    2
`define QHS_CTRL_DC_LO    4
`define QHS_CTRL_DC_HI    5
`define QHS_REQ_SW_LO     0
`define QHS_REQ_RLY_LO    4
`define QHS_ST_FAULT      16

`define QHS_RESP_OKAY     2'h0
`define QHS_RESP_SLVERR   2'h2

`endif

// ### logic/qhs_pkg.sv
`include "qhs_params.svh"

package qhs_pkg;

  typedef enum logic [1:0] {
    QHS_SW_IDLE,
    QHS_SW_ON,
    QHS_SW_OC_OFF,
    QHS_SW_OPEN_OFF
  } qhs_sw_e;

  typedef struct packed {
    logic [1:0] duty_select;
    logic       retry_enable;
    logic       opencircuit_enable;
    logic       status_select;
  } qhs_ctrl_s;

  typedef struct packed {
    logic [3:0] cur_limit;
    logic [3:0] full_on;
    logic [3:0] open_cur;
    logic       undervoltage_lockout;
  } qhs_ana_s;

  // Off-time in ticks: overcurrent time times (100 / duty percent - 1).
  function automatic logic [23:0] qhs_off_ticks(input logic [15:0] to, input logic [1:0] dc);
    logic [23:0] mult;
    mult = (dc == `QHS_DC_LOW)  ? 24'(100 / `QHS_DUTY_LOW_PCT - 1) :
           (dc == `QHS_DC_HIGH) ? 24'(100 / `QHS_DUTY_HIGH_PCT - 1) :
                                  24'(100 / `QHS_DUTY_OPEN_PCT - 1);
    qhs_off_ticks = 24'(to) * mult;
  endfunction : qhs_off_ticks

endpackage : qhs_pkg

// ### logic/qhs_top.sv
// Operation
// - Shared open-drain fault_n pulls low on a fault in any port.
// - fault_n low while any port is open-latched or retrying after overcurrent.
// - Without retry, overcurrent latch keeps fault_n low until switch_request falls.
// - status_out shows power_good when status_select high, else port_open_flag.
// - power_good needs request, switch fully on, supply good, no current limit.
// - port_open_flag high only while latched off by low current.
// - opencircuit_enable enables open-circuit detection on all ports.
// - Open detection arms 900 ms after power-good conditions are met.
// - retry_enable high retries after overcurrent; low latches the switch off.
// - Falling switch_request clears a latched-off switch.
// - duty_select picks off-time duty: 1% low, 2% high, 4% unconnected.
// - relay_request high enables relay; low turns switch off and relay off.
// - Gate enabled only while switch_request and relay_request are both high.
// - Low switch_request disables the gate drive.
// - Low switch_request resets overcurrent latch without retry, and open latch always.
// - Overcurrent time is programmable, default 6.4 ms.
// - Undervoltage holds every switch and relay off.
// - relay_drive polarity is variant dependent, active low or active high.
// - Relay turns on at once; switch_request acts only after 25.6 ms.
// - Relay request low: switch off at once, relay off after 3.2 ms.
// - Current limit beyond the overcurrent time latches the switch off.
// - With retry the switch restarts after the duty-derived off-time.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`include "qhs_params.svh"

module qhs_top #(
  parameter int TICK_CYCLES       = `QHS_TICK_CYCLES,
  parameter bit RELAY_ACTIVE_HIGH = 1'b1
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [3:0]  cur_limit_in,
  input  wire logic [3:0]  full_on_in,
  input  wire logic [3:0]  open_cur_in,
  input  wire logic        undervoltage_lockout_in,
  output logic [3:0]       gate_en,
  output logic [3:0]       relay_drive,
  output logic [3:0]       status_out,
  output logic             fault_n_o,
  output logic             fault_n_oe_n
);

  localparam logic [15:0] TICK_MAX  = 16'(TICK_CYCLES - 1);
  localparam logic [8:0]  TON_LAST  = 9'(`QHS_TON_TICKS - 1);
  localparam logic [8:0]  TOFF_LAST = 9'(`QHS_TOFF_TICKS - 1);
  localparam logic [13:0] OPEN_MAX  = 14'(`QHS_OPEN_TICKS);

  logic [1:0]       rst_q;
  logic             rst_n;
  qhs_pkg::qhs_ana_s ana_m;
  qhs_pkg::qhs_ana_s ana;
  logic [15:0]      tick_cnt;
  logic             tick;

  qhs_pkg::qhs_ctrl_s ctrl;
  logic [3:0]       sw_req;
  logic [3:0]       rly_req;
  logic [15:0]      oc_time;

  logic             aw_have;
  logic             w_have;
  logic [4:0]       aw_addr_q;
  logic [31:0]      w_data_q;
  logic [3:0]       w_strb_q;

  qhs_pkg::qhs_sw_e st [4];
  qhs_pkg::qhs_sw_e next_st [4];
  logic [23:0]      cnt [4];
  logic [23:0]      next_cnt [4];
  logic [13:0]      od [4];
  logic [13:0]      next_od [4];
  logic [8:0]       rcnt [4];
  logic [8:0]       next_rcnt [4];
  logic [3:0]       clr;
  logic [3:0]       next_clr;
  logic [3:0]       rly_on;
  logic [3:0]       next_rly_on;
  logic [3:0]       ready;
  logic [3:0]       next_ready;
  logic [3:0]       sw_prev;
  logic [3:0]       rly_prev;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) rst_q <= 2'h0;
    else         rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  // The second stage alone feeds the port logic.
  // Reset reads as undervoltage, so no port can start before the supply is seen.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ana_m <= 13'h0001;
      ana   <= 13'h0001;
    end else begin
      ana_m <= {cur_limit_in, full_on_in, open_cur_in, undervoltage_lockout_in};
      ana   <= ana_m;
    end
  end

  assign tick = (tick_cnt == TICK_MAX);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) tick_cnt <= 16'h0000;
    else        tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
  end

  // Register bus: write address and data are held until both have arrived.
  wire wr_go   = aw_have && w_have && !s_axi_bvalid;
  wire wr_ctrl = wr_go && (aw_addr_q == `QHS_OFF_CTRL);
  wire wr_req  = wr_go && (aw_addr_q == `QHS_OFF_PORT_REQ);
  wire wr_ot   = wr_go && (aw_addr_q == `QHS_OFF_OC_TIME);
  wire wr_ok   = wr_ctrl || wr_req || wr_ot;

  assign s_axi_awready = !aw_have;
  assign s_axi_wready  = !w_have;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_have   <= 1'b0;
      w_have    <= 1'b0;
      aw_addr_q <= 5'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_have) begin
        aw_have   <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have <= 1'b0;
      end
      if (s_axi_wvalid && !w_have) begin
        w_have   <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl         <= '{duty_select: `QHS_DC_OPEN, default: 1'b0};
      sw_req       <= 4'h0;
      rly_req      <= 4'h0;
      oc_time      <= 16'(`QHS_OC_TICKS);
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `QHS_RESP_OKAY;
    end else begin
      if (wr_ctrl && w_strb_q[0]) begin
        ctrl.status_select      <= w_data_q[`QHS_CTRL_SEL];
        ctrl.opencircuit_enable <= w_data_q[`QHS_CTRL_OPENCIRCUIT_ENABLE];
        ctrl.retry_enable       <= w_data_q[`QHS_CTRL_RETRY];
        ctrl.duty_select        <= w_data_q[`QHS_CTRL_DC_HI:`QHS_CTRL_DC_LO];
      end
      if (wr_req && w_strb_q[0]) begin
        sw_req  <= w_data_q[`QHS_REQ_SW_LO +: 4];
        rly_req <= w_data_q[`QHS_REQ_RLY_LO +: 4];
      end
      if (wr_ot && w_strb_q[0]) oc_time[7:0]  <= w_data_q[7:0];
      if (wr_ot && w_strb_q[1]) oc_time[15:8] <= w_data_q[15:8];
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `QHS_RESP_OKAY : `QHS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Port status seen by software and by the status mux.
  logic [3:0] power_good;
  logic [3:0] open_flag;
  logic [3:0] port_fault;
  logic [3:0] permit;
  logic [3:0] sw_fall;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      power_good[i] = (st[i] == qhs_pkg::QHS_SW_ON) && sw_req[i] && ana.full_on[i] &&
                      !ana.undervoltage_lockout && !ana.cur_limit[i];
      open_flag[i]  = (st[i] == qhs_pkg::QHS_SW_OPEN_OFF);
      port_fault[i] = open_flag[i] || ((st[i] == qhs_pkg::QHS_SW_OC_OFF) && !clr[i]);
      permit[i]     = rly_req[i] && ready[i] && sw_req[i] && !ana.undervoltage_lockout;
    end
  end
  assign sw_fall = sw_prev & ~sw_req;

  wire        any_fault = |port_fault;
  wire [31:0] status_word = {15'h0000, any_fault, rly_on, gate_en, open_flag, power_good};
  wire [31:0] ctrl_word = {26'h0000000, ctrl.duty_select, 1'b0, ctrl.retry_enable,
                           ctrl.opencircuit_enable, ctrl.status_select};
  wire        rd_hit = (s_axi_araddr == `QHS_OFF_CTRL) || (s_axi_araddr == `QHS_OFF_PORT_REQ) ||
                       (s_axi_araddr == `QHS_OFF_OC_TIME) || (s_axi_araddr == `QHS_OFF_STATUS);
  wire [31:0] rd_data =
    (s_axi_araddr == `QHS_OFF_CTRL)     ? ctrl_word :
    (s_axi_araddr == `QHS_OFF_PORT_REQ) ? {24'h000000, rly_req, sw_req} :
    (s_axi_araddr == `QHS_OFF_OC_TIME)  ? {16'h0000, oc_time} :
    (s_axi_araddr == `QHS_OFF_STATUS)   ? status_word : 32'h0000_0000;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `QHS_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_hit ? `QHS_RESP_OKAY : `QHS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Relay sequencing and the per-port switch state machine.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_rly_on[i] = rly_on[i];
      next_ready[i]  = ready[i];
      next_rcnt[i]   = rcnt[i];
      if (ana.undervoltage_lockout) begin
        next_rly_on[i] = 1'b0;
        next_ready[i]  = 1'b0;
        next_rcnt[i]   = 9'h000;
      end else if (rly_req[i] && (!rly_on[i] || !rly_prev[i])) begin
        next_rly_on[i] = 1'b1;
        next_ready[i]  = 1'b0;
        next_rcnt[i]   = 9'h000;
      end else if (!rly_req[i] && rly_prev[i]) begin
        next_ready[i] = 1'b0;
        next_rcnt[i]  = 9'h000;
      end else if (tick && rly_on[i]) begin
        if (rly_req[i] && !ready[i]) begin
          if (rcnt[i] == TON_LAST) next_ready[i] = 1'b1;
          else                     next_rcnt[i]  = rcnt[i] + 9'h001;
        end else if (!rly_req[i]) begin
          if (rcnt[i] == TOFF_LAST) next_rly_on[i] = 1'b0;
          else                      next_rcnt[i]   = rcnt[i] + 9'h001;
        end
      end

      next_st[i]  = st[i];
      next_cnt[i] = cnt[i];
      next_od[i]  = od[i];
      next_clr[i] = clr[i];
      unique case (st[i])
        qhs_pkg::QHS_SW_IDLE: begin
          next_cnt[i] = 24'h000000;
          next_od[i]  = 14'h0000;
          if (permit[i]) next_st[i] = qhs_pkg::QHS_SW_ON;
        end
        qhs_pkg::QHS_SW_ON: begin
          if (!permit[i]) begin
            next_st[i] = qhs_pkg::QHS_SW_IDLE;
          end else if (tick && ana.cur_limit[i] && (cnt[i] + 24'h000001 >= 24'(oc_time))) begin
            next_st[i]  = qhs_pkg::QHS_SW_OC_OFF;
            next_cnt[i] = 24'h000000;
            next_clr[i] = 1'b0;
          end else if ((od[i] == OPEN_MAX) && ctrl.opencircuit_enable && ana.open_cur[i]) begin
            next_st[i]  = qhs_pkg::QHS_SW_OPEN_OFF;
            next_clr[i] = 1'b0;
          end else begin
            if (tick) next_cnt[i] = ana.cur_limit[i] ? cnt[i] + 24'h000001 : 24'h000000;
            if (!power_good[i])             next_od[i] = 14'h0000;
            else if (tick && od[i] != OPEN_MAX) next_od[i] = od[i] + 14'h0001;
          end
        end
        qhs_pkg::QHS_SW_OC_OFF: begin
          if (sw_fall[i]) next_clr[i] = 1'b1;
          if (cnt[i] < qhs_pkg::qhs_off_ticks(oc_time, ctrl.duty_select)) begin
            if (tick) next_cnt[i] = cnt[i] + 24'h000001;
          end else if (ctrl.retry_enable) begin
            next_st[i]  = permit[i] ? qhs_pkg::QHS_SW_ON : qhs_pkg::QHS_SW_IDLE;
            next_cnt[i] = 24'h000000;
            next_od[i]  = 14'h0000;
          end else if (clr[i] || sw_fall[i]) begin
            next_st[i] = qhs_pkg::QHS_SW_IDLE;
          end
        end
        qhs_pkg::QHS_SW_OPEN_OFF: begin
          if (sw_fall[i]) next_st[i] = qhs_pkg::QHS_SW_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        st[i]   <= qhs_pkg::QHS_SW_IDLE;
        cnt[i]  <= 24'h000000;
        od[i]   <= 14'h0000;
        rcnt[i] <= 9'h000;
      end
      clr      <= 4'h0;
      rly_on   <= 4'h0;
      ready    <= 4'h0;
      sw_prev  <= 4'h0;
      rly_prev <= 4'h0;
    end else begin
      st       <= next_st;
      cnt      <= next_cnt;
      od       <= next_od;
      rcnt     <= next_rcnt;
      clr      <= next_clr;
      rly_on   <= next_rly_on;
      ready    <= next_ready;
      sw_prev  <= sw_req;
      rly_prev <= rly_req;
    end
  end

  logic [3:0] next_gate;
  always_comb begin
    for (int i = 0; i < 4; i++) next_gate[i] = (next_st[i] == qhs_pkg::QHS_SW_ON);
  end

  assign fault_n_o = 1'b0;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gate_en      <= 4'h0;
      relay_drive  <= {4{!RELAY_ACTIVE_HIGH}};
      status_out   <= 4'h0;
      fault_n_oe_n <= 1'b1;
    end else begin
      gate_en      <= next_gate;
      relay_drive  <= RELAY_ACTIVE_HIGH ? next_rly_on : ~next_rly_on;
      status_out   <= ctrl.status_select ? power_good : open_flag;
      fault_n_oe_n <= !any_fault;
    end
  end

  a_fault_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    any_fault |=> !fault_n_oe_n) else $error("fault output not driven low on fault");
  a_latch_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st[0] == qhs_pkg::QHS_SW_OC_OFF) && !ctrl.retry_enable && !clr[0] && !sw_fall[0]
    |=> (st[0] == qhs_pkg::QHS_SW_OC_OFF) && !fault_n_oe_n)
    else $error("overcurrent latch released without request drop");
  a_stat_mux: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !ctrl.status_select && $stable(ctrl.status_select) |=> status_out == $past(open_flag))
    else $error("status output not showing open flags");
  a_pg_request: assert property (@(posedge clk_sys) disable iff (!rst_n)
    status_out[0] && $past(ctrl.status_select) |-> $past(sw_req[0], 1) && !$past(ana.undervoltage_lockout, 1))
    else $error("power good without request or supply");
  a_gate_both: assert property (@(posedge clk_sys) disable iff (!rst_n)
    |gate_en |-> ((gate_en & ~$past(sw_req & rly_req & ready)) == 4'h0))
    else $error("gate enabled without both requests");
  a_undervoltage_lockout_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ana.undervoltage_lockout |=> (gate_en == 4'h0) && (rly_on == 4'h0))
    else $error("switch or relay on during undervoltage");
  a_relay_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(rly_on[0]) |-> !gate_en[0] ##1 !gate_en[0][*2])
    else $error("switch on without relay delay");
  a_relay_lag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(rly_req[0]) && rly_on[0] && !ana.undervoltage_lockout |=> !gate_en[0] && rly_on[0])
    else $error("relay dropped before switch");
  a_open_delay: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(open_flag[0]) |-> $past(od[0]) == OPEN_MAX && $past(ctrl.opencircuit_enable))
    else $error("open latch before delay or while disabled");

endmodule : qhs_top

// ### dv/qhs_host.sv
`timescale 1ns/100ps
module qhs_host (
  input  wire logic        clk_sys,
  output logic [4:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [4:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial begin
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
  end

  // Address and data are offered together; each is dropped at the edge that takes it.
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clk_sys); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : qhs_host

// ### dv/testbench.sv
`timescale 1ns/100ps
`include "qhs_params.svh"
module testbench;
  localparam int TC = 4;
  logic             clk_sys = 1'b0;
  logic             arst_n = 1'b0;
  logic [3:0]       cur_limit_in = 4'h0, full_on_in = 4'h0, open_cur_in = 4'h0;
  logic             undervoltage_lockout_in = 1'b0;
  wire logic [4:0]  awaddr, araddr;
  wire logic [31:0] wdata, rdata;
  wire logic [3:0]  wstrb, gate_en, relay_drive, status_out, relay_drive_lo;
  wire logic [1:0]  bresp, rresp;
  wire logic        awvalid, awready, wvalid, wready, bvalid, bready;
  wire logic        arvalid, arready, rvalid, rready, fault_n_o, fault_n_oe_n;
  wire logic        fault_n;
  int               fails = 0, checks = 0;

  // The shared fault line has a pull-up and is only ever pulled low.
  assign fault_n = fault_n_oe_n ? 1'b1 : fault_n_o;
  always #5 clk_sys = ~clk_sys;

  qhs_top #(.TICK_CYCLES(TC), .RELAY_ACTIVE_HIGH(1'b1)) dut_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cur_limit_in(cur_limit_in), .full_on_in(full_on_in), .open_cur_in(open_cur_in),
    .undervoltage_lockout_in(undervoltage_lockout_in), .gate_en(gate_en),
    .relay_drive(relay_drive), .status_out(status_out), .fault_n_o(fault_n_o),
    .fault_n_oe_n(fault_n_oe_n));

  // A copy built as the active-low relay variant; it sees the same traffic as dut_u.
  qhs_top #(.TICK_CYCLES(TC), .RELAY_ACTIVE_HIGH(1'b0)) dut_lo_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(),
    .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
    .cur_limit_in(cur_limit_in), .full_on_in(full_on_in), .open_cur_in(open_cur_in),
    .undervoltage_lockout_in(undervoltage_lockout_in), .gate_en(),
    .relay_drive(relay_drive_lo), .status_out(), .fault_n_o(), .fault_n_oe_n());

  qhs_host host_u (
    .clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  task automatic conclude();
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic reg_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    host_u.wr(a, d, r);
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask : reg_wr

  task automatic reg_rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    host_u.rd(a, d, r);
    chk("rdata", d, ed);
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask : reg_rd

  task automatic t_reset();
    chk("fault_n", fault_n, 1);
    chk("gate_en", gate_en, 0);
    chk("relay_drive_lo", relay_drive_lo, 4'hF);
    reg_rd(`QHS_OFF_CTRL, 32'h20, `QHS_RESP_OKAY);
    reg_rd(`QHS_OFF_PORT_REQ, 32'h0, `QHS_RESP_OKAY);
    reg_rd(`QHS_OFF_OC_TIME, 32'h40, `QHS_RESP_OKAY);
    reg_rd(5'h10, 32'h0, `QHS_RESP_SLVERR);
    reg_wr(`QHS_OFF_STATUS, 32'h0, `QHS_RESP_SLVERR);
  endtask : t_reset

  task automatic t_turn_on();
    reg_wr(`QHS_OFF_CTRL, 32'h01, `QHS_RESP_OKAY);
    reg_wr(`QHS_OFF_OC_TIME, 32'h04, `QHS_RESP_OKAY);
    @(posedge clk_sys);
    full_on_in <= 4'h1;
    reg_wr(`QHS_OFF_PORT_REQ, 32'h11, `QHS_RESP_OKAY);
    cyc(4);
    chk("relay_drive", relay_drive, 4'h1);
    chk("relay_drive_lo", relay_drive_lo, 4'hE);
    cyc(996);
    chk("gate_en", gate_en, 4'h0);
    cyc(40);
    chk("gate_en", gate_en, 4'h1);
    chk("status_out", status_out, 4'h1);
    reg_rd(`QHS_OFF_STATUS, 32'h1101, `QHS_RESP_OKAY);
    reg_wr(`QHS_OFF_CTRL, 32'h00, `QHS_RESP_OKAY);
    cyc(3);
    chk("status_out", status_out, 4'h0);
    reg_wr(`QHS_OFF_CTRL, 32'h01, `QHS_RESP_OKAY);
  endtask : t_turn_on

  task automatic t_oc_latch();
    @(posedge clk_sys);
    cur_limit_in <= 4'h1;
    cyc(5);
    chk("status_out", status_out, 4'h0);
    cyc(40);
    chk("gate_en", gate_en, 4'h0);
    chk("fault_n", fault_n, 0);
    @(posedge clk_sys);
    cur_limit_in <= 4'h0;
    cyc(300);
    chk("gate_en", gate_en, 4'h0);
    chk("fault_n", fault_n, 0);
    reg_wr(`QHS_OFF_PORT_REQ, 32'h10, `QHS_RESP_OKAY);
    cyc(4);
    chk("fault_n", fault_n, 1);
    cyc(1700);
    reg_wr(`QHS_OFF_PORT_REQ, 32'h11, `QHS_RESP_OKAY);
    cyc(4);
    chk("gate_en", gate_en, 4'h1);
  endtask : t_oc_latch

  task automatic t_retry();
    int pct[3] = '{1, 2, 4};
    int n;
    int exp;
    for (int i = 0; i < 3; i++) begin
      reg_wr(`QHS_OFF_CTRL, 32'h05 | (i << 4), `QHS_RESP_OKAY);
      @(posedge clk_sys);
      cur_limit_in <= 4'h1;
      n = 0;
      while (gate_en[0] && n < 100) begin
        cyc(1);
        n++;
      end
      @(posedge clk_sys);
      cur_limit_in <= 4'h0;
      cyc(1);
      chk("fault_n", fault_n, 0);
      n = 2;
      while (!gate_en[0] && n < 3000) begin
        cyc(1);
        n++;
      end
      exp = 4 * TC * (100 / pct[i] - 1);
      chk("off_time_ok", n >= exp - 10 && n <= exp + 12, 1);
      cyc(6);
      chk("fault_n", fault_n, 1);
    end
  endtask : t_retry

  task automatic t_open();
    int n;
    reg_wr(`QHS_OFF_CTRL, 32'h02, `QHS_RESP_OKAY);
    reg_wr(`QHS_OFF_PORT_REQ, 32'h10, `QHS_RESP_OKAY);
    reg_wr(`QHS_OFF_PORT_REQ, 32'h11, `QHS_RESP_OKAY);
    @(posedge clk_sys);
    open_cur_in <= 4'h1;
    cyc(30000);
    chk("gate_en", gate_en, 4'h1);
    n = 30001;
    while (gate_en[0] && n < 40000) begin
      cyc(1);
      n++;
    end
    chk("open_delay_ok", n >= 9000 * TC - 8 && n <= 9000 * TC + 20, 1);
    cyc(3);
    chk("status_out", status_out, 4'h1);
    chk("fault_n", fault_n, 0);
    reg_wr(`QHS_OFF_PORT_REQ, 32'h10, `QHS_RESP_OKAY);
    open_cur_in <= 4'h0;
    cyc(4);
    chk("status_out", status_out, 4'h0);
    chk("fault_n", fault_n, 1);
  endtask : t_open

  task automatic t_relay_uv();
    reg_wr(`QHS_OFF_PORT_REQ, 32'h11, `QHS_RESP_OKAY);
    cyc(4);
    chk("gate_en", gate_en, 4'h1);
    reg_wr(`QHS_OFF_PORT_REQ, 32'h01, `QHS_RESP_OKAY);
    cyc(4);
    chk("gate_en", gate_en, 4'h0);
    cyc(100);
    chk("relay_drive", relay_drive, 4'h1);
    cyc(40);
    chk("relay_drive", relay_drive, 4'h0);
    reg_wr(`QHS_OFF_PORT_REQ, 32'h11, `QHS_RESP_OKAY);
    cyc(1100);
    chk("gate_en", gate_en, 4'h1);
    @(posedge clk_sys);
    undervoltage_lockout_in <= 1'b1;
    cyc(6);
    chk("gate_en", gate_en, 4'h0);
    chk("relay_drive", relay_drive, 4'h0);
    chk("relay_drive_lo", relay_drive_lo, 4'hF);
  endtask : t_relay_uv

  initial begin
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    cyc(4);
    t_reset();
    t_turn_on();
    t_oc_latch();
    t_retry();
    t_open();
    t_relay_uv();
    conclude();
  end

  // The whole sequence needs about 43,000 cycles.
  initial begin
    #800000;
    fails++;
    conclude();
  end
endmodule : testbench
